/* src/fcs_once_store.v */
// Reserved one-time field: eight phrases of four words with written marks
`default_nettype none
module fcs_once_store (
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [2:0] idx_i,
  input wire [63:0] data_i,
  output wire used_o,
  output wire [63:0] data_o
);
`include "fcs_regs.vh"
  reg [63:0] mem [0:`FCS_PHRASES-1];
  reg [`FCS_PHRASES-1:0] used;
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      used <= 8'h00;
      for (i = 0; i < `FCS_PHRASES; i = i + 1) begin
        mem[i] <= `FCS_ERASED;
      end
    end else if (wr_i && !used[idx_i]) begin
      mem[idx_i] <= data_i;
      used[idx_i] <= 1'b1;
    end
  end
  assign used_o = used[idx_i];
  assign data_o = mem[idx_i];
endmodule // fcs_once_store
`default_nettype wire

/* src/fcs_regs.vh */
// Register map, field positions and constants of the flash command sequencer
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
`define FCS_ADR_W 8
`define FCS_OFS_DIV 8'h00
`define FCS_OFS_STAT 8'h04
`define FCS_OFS_IDX 8'h08
`define FCS_OFS_PARAM 8'h0c
`define FCS_OFS_CTRL 8'h10
`define FCS_OFS_IRQ_STAT 8'h14
`define FCS_OFS_IRQ_MASK 8'h18
`define FCS_OFS_RSV4 8'h13
`define FCS_OFS_PROT 8'h20
`define FCS_DIV_LOADED_BIT 7
`define FCS_ST_CCF 7
`define FCS_ST_ACC 5
`define FCS_ST_PV 4
`define FCS_ST_VE 1
`define FCS_ST_UE 0
`define FCS_CMD_PROG 8'h06
`define FCS_CMD_ONCE 8'h07
`define FCS_IDX_PROG 3'h5
`define FCS_IDX_ONCE 3'h5
`define FCS_ONCE_MAX 16'h0007
`define FCS_PHRASES 8
`define FCS_ERASED 64'hffffffffffffffff
`define FCS_ALIGN_MASK 3'h7
`define FCS_FLASH_TOP 7'h7f
`define FCS_FLASH_BOT 7'h78
`define FCS_TB_CNT_W 7
`define FCS_OP_CYCLES 8'h20
`define FCS_IRQ_DONE 0
`define FCS_IRQ_ERR 1
`endif

/* src/fcs_timebase.v */
// Divides the oscillator clock down to the program timebase
`default_nettype none
module fcs_timebase (
  input wire clk_i,
  input wire rst_i,
  input wire osc_i,
  input wire [6:0] div_i,
  output reg tick_o
);
`include "fcs_regs.vh"
  reg osc_s0;
  reg osc_s1;
  reg osc_d;
  reg [`FCS_TB_CNT_W-1:0] cnt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      osc_s0 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_d <= 1'b0;
      cnt <= 7'h00;
      tick_o <= 1'b0;
    end else begin
      osc_s0 <= osc_i;
      osc_s1 <= osc_s0;
      osc_d <= osc_s1;
      tick_o <= 1'b0;
      if (osc_s1 && !osc_d) begin
        // Divide by div+1 oscillator periods
        if (cnt >= div_i) begin
          cnt <= 7'h00;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + 7'h01;
        end
      end
    end
  end
endmodule // fcs_timebase
`default_nettype wire

/* src/fcs_top.v */
// Flash command sequencer: timebase divider, program checks, program-once field
// How it works
// - A divider write while the complete flag is set sets the loaded flag; clear means unwritten
// - Unloaded divider: any command refused, access error set
// - Program command with index pointer not 101 sets access error
// - Program command in a mode lacking it sets access error
// - Invalid 23-bit global address on program sets access error
// - Program address low three bits not zero sets access error
// - Protected address sets protection violation and skips programming
// - Verify sets the error status bit and the uncorrectable status bit
// - Program-once writes only the 8-phrase reserved field
// - Launch checks (erased only for program-once), programs, verifies, then sets complete flag
// - A second program of a used reserved phrase is refused
`default_nettype none
module fcs_top (
  input wire clk_i,
  input wire rst_i,
  input wire osc_i,
  input wire mode_ok_i,
  input wire verify_err_i,
  input wire verify_unc_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg busy_o,
  output reg irq_o
);
`include "fcs_regs.vh"
  localparam ST_IDLE = 4'h1;
  localparam ST_CHECK = 4'h2;
  localparam ST_WORK = 4'h4;
  localparam ST_DONE = 4'h8;

  reg [6:0] div_ratio;
  reg div_loaded;
  reg acc_err;
  reg prot_err;
  reg ver_err;
  reg unc_err;
  reg ccf;
  reg [2:0] cidx;
  reg [15:0] param [0:5];
  reg [6:0] prot_lo;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg [3:0] state;
  reg [7:0] work_cnt;
  reg mode_s0;
  reg mode_s1;
  reg ve_s0;
  reg ve_s1;
  reg ue_s0;
  reg ue_s1;
  reg once_wr;
  reg is_once;
  wire tick;
  wire once_used;
  wire [63:0] once_q;
  wire [22:0] gaddr;
  wire acc;
  wire wr;
  wire rd;
  wire [7:0] stat_byte;
  integer k;
  reg [31:0] next_rdata;
  wire [7:0] cmd_code;
  wire done_evt;
  wire err_evt;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign rd = acc && !wb_we_i;
  assign gaddr = {param[0][6:0], param[1]};
  assign stat_byte = {ccf, 1'b0, acc_err, prot_err, 2'b00, ver_err, unc_err};
  assign cmd_code = param[0][15:8];
  assign done_evt = (state == ST_DONE);
  assign err_evt = done_evt && (acc_err || prot_err || ver_err);

  // Program address is valid if inside the flash window
  function addr_ok;
    input [22:0] a;
    begin
      addr_ok = (a[22:16] >= `FCS_FLASH_BOT) && (a[22:16] <= `FCS_FLASH_TOP);
    end
  endfunction

  // Write strobe of one register offset
  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = wr && (wb_adr_i == ofs);
    end
  endfunction

  fcs_timebase u_tb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_i(osc_i),
    .div_i(div_ratio),
    .tick_o(tick)
  );

  fcs_once_store u_once (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(once_wr),
    .idx_i(param[1][2:0]),
    .data_i({param[2], param[3], param[4], param[5]}),
    .used_o(once_used),
    .data_o(once_q)
  );

  // Synchronise external status levels
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_s0 <= 1'b0;
      mode_s1 <= 1'b0;
      ve_s0 <= 1'b0;
      ve_s1 <= 1'b0;
      ue_s0 <= 1'b0;
      ue_s1 <= 1'b0;
    end else begin
      mode_s0 <= mode_ok_i;
      mode_s1 <= mode_s0;
      ve_s0 <= verify_err_i;
      ve_s1 <= ve_s0;
      ue_s0 <= verify_unc_i;
      ue_s1 <= ue_s0;
    end
  end

  // Read data of the addressed register
  always @* begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `FCS_OFS_DIV: next_rdata = {24'h000000, div_loaded, div_ratio};
      `FCS_OFS_STAT: next_rdata = {24'h000000, stat_byte};
      `FCS_OFS_IDX: next_rdata = {29'h00000000, cidx};
      `FCS_OFS_PARAM: begin
        if (cidx <= `FCS_IDX_PROG) begin
          next_rdata = {16'h0000, param[cidx]};
        end
      end
      `FCS_OFS_PROT: next_rdata = {25'h0000000, prot_lo};
      `FCS_OFS_IRQ_STAT: next_rdata = {30'h00000000, irq_stat};
      `FCS_OFS_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
      `FCS_OFS_CTRL: next_rdata = {31'h00000000, is_once};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Sticky interrupt status, mask and level output
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
      if (wr_hit(`FCS_OFS_IRQ_MASK) && ccf) begin
        irq_mask <= wb_dat_i[1:0];
      end
      if (wr_hit(`FCS_OFS_IRQ_STAT)) begin
        irq_stat <= irq_stat & ~wb_dat_i[1:0];
      end
      if (done_evt) begin
        irq_stat[`FCS_IRQ_DONE] <= 1'b1;
      end
      if (err_evt) begin
        irq_stat[`FCS_IRQ_ERR] <= 1'b1;
      end
    end
  end

  // Bus slave, register file and command sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      div_ratio <= 7'h00;
      div_loaded <= 1'b0;
      acc_err <= 1'b0;
      prot_err <= 1'b0;
      ver_err <= 1'b0;
      unc_err <= 1'b0;
      ccf <= 1'b1;
      cidx <= 3'h0;
      prot_lo <= 7'h7f;
      state <= ST_IDLE;
      work_cnt <= 8'h00;
      once_wr <= 1'b0;
      is_once <= 1'b0;
      busy_o <= 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        param[k] <= 16'h0000;
      end
    end else begin
      wb_ack_o <= acc;
      once_wr <= 1'b0;
      busy_o <= (state != ST_IDLE);
      if (rd) begin
        wb_dat_o <= next_rdata;
      end
      if (wr && ccf) begin
        case (wb_adr_i)
          `FCS_OFS_DIV: begin
            div_ratio <= wb_dat_i[6:0];
            div_loaded <= 1'b1;
          end
          `FCS_OFS_IDX: cidx <= wb_dat_i[2:0];
          `FCS_OFS_PARAM: begin
            if (cidx <= 3'h5) begin
              param[cidx] <= wb_dat_i[15:0];
            end
          end
          `FCS_OFS_PROT: prot_lo <= wb_dat_i[6:0];
          default: ;
        endcase
      end
      // Write-one clears access and protection errors; launch by writing one to complete flag
      if (wr_hit(`FCS_OFS_STAT)) begin
        if (wb_dat_i[`FCS_ST_ACC]) begin
          acc_err <= 1'b0;
        end
        if (wb_dat_i[`FCS_ST_PV]) begin
          prot_err <= 1'b0;
        end
        if (wb_dat_i[`FCS_ST_CCF] && ccf && !acc_err && !prot_err) begin
          ccf <= 1'b0;
          ver_err <= 1'b0;
          unc_err <= 1'b0;
          state <= ST_CHECK;
        end
      end
      case (state)
        ST_IDLE: ;
        ST_CHECK: begin
          is_once <= (cmd_code == `FCS_CMD_ONCE);
          state <= ST_DONE;
          if (!div_loaded) begin
            acc_err <= 1'b1;
          end else if (cmd_code == `FCS_CMD_PROG) begin
            if (cidx != `FCS_IDX_PROG) begin
              acc_err <= 1'b1;
            end else if (!mode_s1) begin
              acc_err <= 1'b1;
            end else if (!addr_ok(gaddr)) begin
              acc_err <= 1'b1;
            end else if ((gaddr[2:0] & `FCS_ALIGN_MASK) != 3'h0) begin
              acc_err <= 1'b1;
            end else if (gaddr[22:16] >= prot_lo) begin
              prot_err <= 1'b1;
            end else begin
              work_cnt <= 8'h00;
              state <= ST_WORK;
            end
          end else if (cmd_code == `FCS_CMD_ONCE) begin
            if (cidx != `FCS_IDX_ONCE || !mode_s1) begin
              acc_err <= 1'b1;
            end else if (param[1] > `FCS_ONCE_MAX) begin
              acc_err <= 1'b1;
            end else if (once_used) begin
              acc_err <= 1'b1;
            end else if (once_q != `FCS_ERASED) begin
              acc_err <= 1'b1;
            end else begin
              work_cnt <= 8'h00;
              state <= ST_WORK;
            end
          end else begin
            acc_err <= 1'b1;
          end
        end
        ST_WORK: begin
          // Timed programming on the divided timebase
          if (tick) begin
            work_cnt <= work_cnt + 8'h01;
          end
          if (work_cnt == `FCS_OP_CYCLES) begin
            once_wr <= is_once;
            state <= ST_DONE;
            ver_err <= ve_s1;
            unc_err <= ue_s1;
          end
        end
        ST_DONE: begin
          ccf <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // fcs_top
`default_nettype wire

/* tb/fcs_top_properties.sv */
// Port checker of the flash command sequencer
`default_nettype none
`include "fcs_regs.vh"
module fcs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic ld;
  logic [3:0] age;
  wire logic rd = wb_ack_o & !wb_we_i;
  wire logic wr = wb_ack_o & wb_we_i & wb_sel_i[0];
  wire logic go = wr & (wb_adr_i == `FCS_OFS_STAT) & wb_dat_i[`FCS_ST_CCF];
  wire logic rdiv = rd & (wb_adr_i == `FCS_OFS_DIV);
  wire logic rst = rd & (wb_adr_i == `FCS_OFS_STAT);
  // Divider written flag and cycles since launch
  always @(posedge clk_i) begin
    if (rst_i) begin
      ld <= 1'b0;
      age <= 4'hf;
    end else begin
      if (wr & (wb_adr_i == `FCS_OFS_DIV))
        ld <= 1'b1;
      if (go)
        age <= 4'h0;
      else if (age != 4'hf)
        age <= age + 4'h1;
    end
  end
  AST_ACK_ONE: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_DIV_SET: assert property (rdiv & ld |-> wb_dat_o[`FCS_DIV_LOADED_BIT])
    else $error("loaded flag clear");
  AST_DIV_CLR: assert property (rdiv & !ld |-> !wb_dat_o[`FCS_DIV_LOADED_BIT])
    else $error("loaded flag set");
  AST_NO_RUN: assert property (go & !ld |-> ##6 !busy_o [*8])
    else $error("ran without divider");
  AST_RSV4_ZERO: assert property (rd & (wb_adr_i == `FCS_OFS_RSV4) |-> wb_dat_o == 32'h0)
    else $error("reserved not zero");
  AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> age <= 4'h5)
    else $error("busy without launch");
  AST_CCF_LOW: assert property (rst & busy_o & $past(busy_o) & $past(busy_o, 2) |->
    !wb_dat_o[`FCS_ST_CCF]) else $error("complete while busy");
endmodule // fcs_chk
bind fcs_top fcs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
`default_nettype wire

/* tb/fcs_top_tb.sv */
// Self-checking bench of the flash command sequencer
`default_nettype none
`include "fcs_regs.vh"
module fcs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, osc_i = 1'b0, mode_ok_i = 1'b1;
  logic verify_err_i = 1'b0, verify_unc_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, busy_o, irq_o;
  logic [31:0] q_exp[$], q_msk[$], p[6];
  logic [7:0] r = 8'h62;
  int mismatches = 0, n_compared = 0, cyc_n = 0;
  fcs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .osc_i(osc_i), .mode_ok_i(mode_ok_i),
    .verify_err_i(verify_err_i), .verify_unc_i(verify_unc_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o),
    .irq_o(irq_o));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) osc_i <= ~osc_i;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read results against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o && !wb_we_i)
      cmp("read data", q_exp.pop_front(), wb_dat_o & q_msk.pop_front());
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      mismatches++;
      results();
    end
  end
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, e, m);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!we) begin
      q_exp.push_back(e);
      q_msk.push_back(m);
    end
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, e, m);
  endtask
  task automatic st(input logic [31:0] e);
    rd(`FCS_OFS_STAT, e, 32'hb3);
    wr(`FCS_OFS_STAT, 32'h30);
  endtask
  task automatic ck_irq(input logic e);
    repeat (2) @(posedge clk_i);
    cmp("irq", {31'h0, e}, {31'h0, irq_o});
  endtask
  // Load n slots, launch, wait out the command
  task automatic run(input int n, input logic b);
    for (int i = 0; i < n; i++) begin
      wr(`FCS_OFS_IDX, 32'(i));
      wr(`FCS_OFS_PARAM, p[i]);
    end
    wr(`FCS_OFS_STAT, 32'h80);
    repeat (8) @(posedge clk_i);
    cmp("busy", {31'h0, b}, {31'h0, busy_o});
    if (b)
      rd(`FCS_OFS_STAT, 32'h0, 32'h80);
    while (busy_o)
      @(posedge clk_i);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`FCS_OFS_DIV, 32'h0, 32'hff);
    rd(`FCS_OFS_RSV4, 32'h0, 32'hffffffff);
    rd(`FCS_OFS_PROT, 32'h7f, 32'h7f);
    rd(8'hfc, 32'h0, 32'hffffffff);
    st(32'h80);
    $display("reset test done");
    p[0] = {16'h0, `FCS_CMD_PROG, 8'h78};
    p[1] = 32'h0;
    for (int i = 2; i < 6; i++) begin
      r = lfsr(r);
      p[i] = {16'h0, r, ~r};
    end
    run(6, 1'b0);
    ck_irq(1'b0);
    wr(`FCS_OFS_IRQ_MASK, 32'h2);
    ck_irq(1'b1);
    rd(`FCS_OFS_IRQ_STAT, 32'h3, 32'h3);
    wr(`FCS_OFS_IRQ_STAT, 32'h3);
    ck_irq(1'b0);
    st(32'ha0);
    $display("unloaded test done");
    wr(`FCS_OFS_DIV, {25'h0, 7'(r % 8'h2f + 8'h1)});
    rd(`FCS_OFS_DIV, {24'h0, 1'b1, 7'(r % 8'h2f + 8'h1)}, 32'hff);
    for (int k = 0; k < 5; k++) begin
      p[0] = {16'h0, `FCS_CMD_PROG, k == 2 ? 8'h10 : k == 4 ? 8'h7f : 8'h78};
      p[1] = k == 3 ? 32'h3 : 32'h0;
      mode_ok_i <= k != 1;
      run(k == 0 ? 5 : 6, 1'b0);
      st(k == 4 ? 32'h90 : 32'ha0);
    end
    p[0] = {16'h0, `FCS_CMD_PROG, 8'h78};
    p[1] = {16'h0, r, 8'h08};
    verify_err_i <= 1'b1;
    verify_unc_i <= 1'b1;
    run(6, 1'b1);
    st(32'h83);
    $display("program test done");
    verify_err_i <= 1'b0;
    verify_unc_i <= 1'b0;
    p[0] = {16'h0, `FCS_CMD_ONCE, 8'h0};
    p[1] = {29'h0, r[2:0]};
    run(6, 1'b1);
    st(32'h80);
    rd(`FCS_OFS_CTRL, 32'h1, 32'h1);
    rd(`FCS_OFS_IDX, 32'h5, 32'h7);
    rd(`FCS_OFS_PARAM, p[5], 32'hffff);
    run(6, 1'b0);
    st(32'ha0);
    p[1] = 32'h8;
    run(6, 1'b0);
    st(32'ha0);
    $display("once test done");
    results();
  end
endmodule // fcs_top_tb
`default_nettype wire
